// File: core/sirq_pkg.sv
// Shared constants, types and helpers for the serial interrupt link
package sirq_pkg;

  // Request slots carried by periods 2 to 16
  localparam int unsigned SIRQ_NREQ        = 15;
  localparam logic [4:0]  SIRQ_FIRST_FRAME = 5'h02;
  localparam logic [4:0]  SIRQ_LAST_FRAME  = 5'h10;
  localparam logic [4:0]  SIRQ_FRAME_MAX   = 5'h1f;
  localparam logic [4:0]  SIRQ_SLOT_OFS    = 5'h01;
  localparam int unsigned SIRQ_MGMT_SLOT   = 2;

  // Stop pulse low widths, in clocks
  localparam logic [1:0]  SIRQ_STOP_QUIET  = 2'h2;
  localparam logic [1:0]  SIRQ_STOP_CONT   = 2'h3;

  // Host defaults: start pulse total width and frames per cycle
  localparam logic [3:0]  SIRQ_START_MIN   = 4'h4;
  localparam logic [3:0]  SIRQ_START_MAX   = 4'h8;
  localparam logic [4:0]  SIRQ_DEF_FRAMES  = 5'h11;

  typedef enum logic [2:0] {
    SIRQ_PH_SAMPLE  = 3'b001,
    SIRQ_PH_RECOVER = 3'b010,
    SIRQ_PH_TURN    = 3'b100
  } sirq_phase_t;

  typedef enum logic {
    SIRQ_CONT  = 1'b0,
    SIRQ_QUIET = 1'b1
  } sirq_mode_t;

  typedef enum logic [3:0] {
    SIRQ_SL_IDLE  = 4'b0001,
    SIRQ_SL_KICK  = 4'b0010,
    SIRQ_SL_START = 4'b0100,
    SIRQ_SL_DATA  = 4'b1000
  } sirq_sl_state_t;

  typedef enum logic [5:0] {
    SIRQ_H_IDLE   = 6'b000001,
    SIRQ_H_START  = 6'b000010,
    SIRQ_H_HIGH   = 6'b000100,
    SIRQ_H_DATA   = 6'b001000,
    SIRQ_H_STOP   = 6'b010000,
    SIRQ_H_STOPHI = 6'b100000
  } sirq_h_state_t;

  function automatic sirq_phase_t sirq_next_phase(input sirq_phase_t p);
    case (p)
      SIRQ_PH_SAMPLE:  return SIRQ_PH_RECOVER;
      SIRQ_PH_RECOVER: return SIRQ_PH_TURN;
      default:         return SIRQ_PH_SAMPLE;
    endcase
  endfunction

endpackage

// File: core/sirq_if.sv
// Shared serial interrupt wire with one modport per end
interface sirq_if;
  logic line;
  logic sl_o;
  logic sl_oe;
  logic ho_o;
  logic ho_oe;

  // Pulled high when nobody drives; a driven low always wins
  assign line = (sl_oe ? sl_o : 1'b1) & (ho_oe ? ho_o : 1'b1);

  modport slave (input line, output sl_o, output sl_oe);
  modport host  (input line, output ho_o, output ho_oe);
endinterface

// File: core/sirq_slave.sv
// Device end of the serial interrupt link: reports request levels in slots

// Behaviour
// - Quiet idle: drive one low clock, never high
// - Host extends start low to 4-8 clocks
// - Host drives high one clock, then releases
// - Quiet mode: request change triggers start frame
// - Continuous mode: device never starts a cycle
// - Mode changes only at stop; reset continuous
// - Stop low 2 means quiet, 3 continuous
// - Start no earlier than second clock after stop
// - Only host generates stop frames
// - Count 3-clock frames from start rising edge
// - Sample phase: drive low if level low
// - Recovery: drive high only after own low
// - Turn-around phase: always release the wire
// - Report low level whoever started the cycle
// - Period n sampled 3n-1 clocks after edge
// - Period 3 carries request 2 or management
// - Enables route management to frame and pin
// - Drive and sample on rising clock edge
// - Reset: wire released, continuous idle mode
// - Host runs first cycle, supplies defaults first
// - Host delays end-of-interrupt reads by latency; this host only pulses cycle_done after each cycle
// - Host goes continuous before suspend or swap
module sirq_slave
  import sirq_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  sirq_if.slave                      bus,
  input  wire logic [SIRQ_NREQ:1]    irq_level,
  input  wire logic                  mgmt_interrupt_n,
  input  wire logic                  mgmt_serial_en,
  input  wire logic                  mgmt_pin_en,
  output logic                       mgmt_interrupt_pin_n,
  output logic                       quiet_mode,
  output logic                       cycle_active
);

  sirq_sl_state_t      state_q;
  sirq_sl_state_t      state_d;
  sirq_mode_t          mode_q;
  sirq_mode_t          mode_d;
  sirq_phase_t         ph_q;
  sirq_phase_t         ph_d;
  logic [4:0]          fr_q;
  logic [4:0]          fr_d;
  logic [4:0]          slot_idx;
  logic [1:0]          lowrun_q;
  logic [SIRQ_NREQ:1]  slot_q;
  logic [SIRQ_NREQ:1]  slot_prev_q;
  logic [SIRQ_NREQ:1]  slot_d;
  logic [SIRQ_NREQ:1]  pend_q;
  logic                oe_q;
  logic                oe_d;
  logic                o_q;
  logic                o_d;
  logic                in_slot;
  logic                deliver;
  logic                mgmt_frame;

  // Management request only joins the frame when its serial enable is set
  assign mgmt_frame = mgmt_serial_en & ~mgmt_interrupt_n;

  // Levels come from logic on this clock, so no synchroniser is needed
  for (genvar k = 1; k <= SIRQ_NREQ; k++) begin : g_slot
    if (k == SIRQ_MGMT_SLOT) begin : g_mgmt
      // Software keeps only one source active on this slot
      assign slot_d[k] = irq_level[k] & ~mgmt_frame;
    end else begin : g_plain
      assign slot_d[k] = irq_level[k];
    end

    // A change seen in the same edge as the delivery keeps the flag set
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        pend_q[k] <= 1'b0;
      end else if (slot_q[k] != slot_prev_q[k]) begin
        pend_q[k] <= 1'b1;
      end else if (deliver && slot_idx == 5'(k)) begin
        pend_q[k] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slot_q      <= '1;
      slot_prev_q <= '1;
    end else begin
      slot_q      <= slot_d;
      slot_prev_q <= slot_q;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_interrupt_pin_n <= 1'b1;
    end else begin
      mgmt_interrupt_pin_n <= ~(mgmt_pin_en & ~mgmt_interrupt_n);
    end
  end

  // Consecutive low clocks on the wire; a data slot is never more than one
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lowrun_q <= '0;
    end else if (bus.line) begin
      lowrun_q <= '0;
    end else if (lowrun_q != SIRQ_STOP_CONT) begin
      lowrun_q <= lowrun_q + 2'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    ph_d    = ph_q;
    fr_d    = fr_q;
    case (state_q)
      SIRQ_SL_IDLE: begin
        if (!bus.line) begin
          // Someone else started; follow their cycle
          state_d = SIRQ_SL_START;
        end else if (mode_q == SIRQ_QUIET && |pend_q) begin
          // Idle is entered one clock after the stop edge, so the
          // earliest kick lands on the second clock after it
          state_d = SIRQ_SL_KICK;
        end
      end
      SIRQ_SL_KICK: begin
        state_d = SIRQ_SL_START;
      end
      SIRQ_SL_START: begin
        if (bus.line) begin
          // First high clock is clock 0; next one is a turn-around
          state_d = SIRQ_SL_DATA;
          ph_d    = SIRQ_PH_TURN;
          fr_d    = '0;
        end
      end
      SIRQ_SL_DATA: begin
        if (bus.line && lowrun_q >= SIRQ_STOP_QUIET) begin
          // Only the host ends a cycle; the width picks the next mode
          state_d = SIRQ_SL_IDLE;
          mode_d  = (lowrun_q == SIRQ_STOP_QUIET) ? SIRQ_QUIET
                                                  : SIRQ_CONT;
        end else begin
          ph_d = sirq_next_phase(ph_q);
          if (ph_q == SIRQ_PH_TURN && fr_q != SIRQ_FRAME_MAX) begin
            fr_d = fr_q + 5'h01;
          end
        end
      end
      default: begin
        state_d = SIRQ_SL_IDLE;
      end
    endcase
  end

  // Frame n sample lands 3n-1 clocks past the start edge
  assign slot_idx = fr_d - SIRQ_SLOT_OFS;
  assign in_slot  = (state_d == SIRQ_SL_DATA) && (ph_d == SIRQ_PH_SAMPLE)
                    && (fr_d >= SIRQ_FIRST_FRAME)
                    && (fr_d <= SIRQ_LAST_FRAME);
  assign deliver  = in_slot;

  // Outputs are decided one edge early so the pin itself is a flop
  always_comb begin
    oe_d = 1'b0;
    o_d  = 1'b0;
    if (state_d == SIRQ_SL_KICK) begin
      oe_d = 1'b1;
    end else if (in_slot && !slot_q[slot_idx[3:0]]) begin
      oe_d = 1'b1;
    end else if (state_d == SIRQ_SL_DATA && ph_d == SIRQ_PH_RECOVER
                 && oe_q && !o_q) begin
      oe_d = 1'b1;
      o_d  = 1'b1;
    end
    // Turn-around, start and idle fall through with the pin released
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
      o_q  <= 1'b0;
    end else begin
      oe_q <= oe_d;
      o_q  <= o_d;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SIRQ_SL_IDLE;
      mode_q  <= SIRQ_CONT;
      ph_q    <= SIRQ_PH_TURN;
      fr_q    <= '0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      ph_q    <= ph_d;
      fr_q    <= fr_d;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      quiet_mode   <= 1'b0;
      cycle_active <= 1'b0;
    end else begin
      quiet_mode   <= (mode_d == SIRQ_QUIET);
      cycle_active <= (state_d != SIRQ_SL_IDLE);
    end
  end

  assign bus.sl_oe = oe_q;
  assign bus.sl_o  = o_q;

endmodule

// File: core/sirq_host.sv
// Host end of the serial interrupt link: runs cycles and collects levels
module sirq_host
  import sirq_pkg::*;
#(
  parameter logic [3:0] START_CLKS = SIRQ_START_MIN,
  parameter logic [4:0] FRAMES     = SIRQ_DEF_FRAMES
)
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  sirq_if.host                       bus,
  input  wire logic                  cycle_go,
  input  wire logic                  quiet_sel,
  output logic [SIRQ_NREQ:1]         irq_level,
  output logic                       quiet_mode,
  output logic                       cycle_done,
  output logic                       levels_valid
);

  sirq_h_state_t state_q;
  sirq_h_state_t state_d;
  sirq_phase_t   ph_q;
  sirq_phase_t   ph_d;
  logic [4:0]    fr_q;
  logic [4:0]    fr_d;
  logic [4:0]    slot_idx;
  logic [3:0]    cnt_q;
  logic [3:0]    cnt_d;
  logic          mode_q;
  logic          mode_d;
  logic          first_q;
  logic          oe_q;
  logic          o_q;

  assign slot_idx = fr_q - SIRQ_SLOT_OFS;

  always_comb begin
    state_d = state_q;
    ph_d    = ph_q;
    fr_d    = fr_q;
    cnt_d   = cnt_q;
    mode_d  = mode_q;
    case (state_q)
      SIRQ_H_IDLE: begin
        if (!bus.line && mode_q) begin
          // Device sent one low clock; keep it low for the rest
          // One low clock is already spent, so the host adds START-1
          state_d = SIRQ_H_START;
          cnt_d   = START_CLKS - 4'h2;
        end else if (first_q || cycle_go) begin
          // Reset forces one collecting cycle before any request
          state_d = SIRQ_H_START;
          cnt_d   = START_CLKS - 4'h1;
        end
      end
      SIRQ_H_START: begin
        if (cnt_q == '0) begin
          state_d = SIRQ_H_HIGH;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      SIRQ_H_HIGH: begin
        state_d = SIRQ_H_DATA;
        ph_d    = SIRQ_PH_TURN;
        fr_d    = '0;
      end
      SIRQ_H_DATA: begin
        if (ph_q == SIRQ_PH_TURN && fr_q == FRAMES) begin
          state_d = SIRQ_H_STOP;
          mode_d  = quiet_sel;
          cnt_d   = quiet_sel ? 4'(SIRQ_STOP_QUIET - 2'h1)
                              : 4'(SIRQ_STOP_CONT - 2'h1);
        end else begin
          ph_d = sirq_next_phase(ph_q);
          if (ph_q == SIRQ_PH_TURN) begin
            fr_d = fr_q + 5'h01;
          end
        end
      end
      SIRQ_H_STOP: begin
        if (cnt_q == '0) begin
          state_d = SIRQ_H_STOPHI;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = SIRQ_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SIRQ_H_IDLE;
      ph_q    <= SIRQ_PH_TURN;
      fr_q    <= '0;
      cnt_q   <= '0;
      mode_q  <= 1'b0;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ph_q    <= ph_d;
      fr_q    <= fr_d;
      cnt_q   <= cnt_d;
      mode_q  <= mode_d;
      if (state_d == SIRQ_H_START) begin
        first_q <= 1'b0;
      end
    end
  end

  // Pin released during reset, data frames and idle
  // High clocks last one cycle and are always followed by release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oe_q <= 1'b0;
      o_q  <= 1'b0;
    end else begin
      oe_q <= (state_d != SIRQ_H_IDLE) && (state_d != SIRQ_H_DATA);
      o_q  <= (state_d == SIRQ_H_HIGH) || (state_d == SIRQ_H_STOPHI);
    end
  end

  // Defaults read as no request until the first cycle samples each slot
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_level    <= '1;
      levels_valid <= 1'b0;
      cycle_done   <= 1'b0;
      quiet_mode   <= 1'b0;
    end else begin
      if (state_q == SIRQ_H_DATA && ph_q == SIRQ_PH_SAMPLE
          && fr_q >= SIRQ_FIRST_FRAME && fr_q <= SIRQ_LAST_FRAME) begin
        irq_level[slot_idx[3:0]] <= bus.line;
      end
      // Consumers may hold end-of-interrupt reads until this pulse
      cycle_done <= (state_q == SIRQ_H_STOPHI);
      if (state_q == SIRQ_H_STOPHI) begin
        levels_valid <= 1'b1;
      end
      quiet_mode <= mode_d;
    end
  end

  assign bus.ho_oe = oe_q;
  assign bus.ho_o  = o_q;

endmodule

// File: test/sirq_checker.sv
// Wire protocol checker for the serial interrupt link
module sirq_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic line,
  input wire logic sl_o,
  input wire logic sl_oe,
  input wire logic ho_o,
  input wire logic ho_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] low_q;
  logic [6:0] pos_q;
  logic       act_q;
  logic       quiet_q;
  wire        sl_lo = sl_oe & ~sl_o;
  wire        sl_hi = sl_oe & sl_o;
  wire        ho_lo = ho_oe & ~ho_o;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      low_q <= 4'h0;
    else if (line)
      low_q <= 4'h0;
    else if (low_q != 4'hf)
      low_q <= low_q + 4'h1;
  end

  // Start lows are 4 or more, stop lows 2 or 3
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act_q   <= 1'b0;
      quiet_q <= 1'b0;
    end else if (line && low_q >= 4'h4) begin
      act_q <= 1'b1;
    end else if (line && act_q && (low_q == 4'h2 || low_q == 4'h3)) begin
      act_q   <= 1'b0;
      quiet_q <= (low_q == 4'h2);
    end
  end

  // Clock number counted from the start pulse rising edge
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      pos_q <= 7'h00;
    else if (line && low_q >= 4'h4)
      pos_q <= 7'h01;
    else if (pos_q != 7'h7f)
      pos_q <= pos_q + 7'h01;
  end

  property p_low_then;
    @(posedge clock) disable iff (!rst_b) sl_lo |=> sl_hi ^ ho_lo;
  endproperty
  a_low_then: assert property (p_low_then)
    else $error("slave low not followed by own high or host low");

  property p_hi_after_low;
    @(posedge clock) disable iff (!rst_b)
      sl_hi |-> $past(sl_oe) && !$past(sl_o);
  endproperty
  a_hi_after_low: assert property (p_hi_after_low)
    else $error("slave high without own low before");

  property p_release;
    @(posedge clock) disable iff (!rst_b) sl_hi |=> !sl_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("slave kept the wire in turn-around");

  property p_hi_gap;
    @(posedge clock) disable iff (!rst_b) ho_oe && ho_o |=> !sl_lo;
  endproperty
  a_hi_gap: assert property (p_hi_gap)
    else $error("slave low right after host high clock");

  property p_start_take;
    @(posedge clock) disable iff (!rst_b)
      !act_q && sl_lo |=> ho_lo [*3];
  endproperty
  a_start_take: assert property (p_start_take)
    else $error("host did not extend the start pulse");

  property p_host_release;
    @(posedge clock) disable iff (!rst_b) ho_oe && ho_o |=> !ho_oe;
  endproperty
  a_host_release: assert property (p_host_release)
    else $error("host held the wire after its high clock");

  property p_reset_off;
    // First reset edge skipped: flops may only settle on that edge
    @(posedge clock) !rst_b && $past(!rst_b) |-> !sl_oe && !ho_oe;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("wire driven during reset");

  property p_cont_no_kick;
    @(posedge clock) disable iff (!rst_b)
      !act_q && !quiet_q |-> !sl_lo;
  endproperty
  a_cont_no_kick: assert property (p_cont_no_kick)
    else $error("slave started a cycle in continuous mode");

  property p_slot_pos;
    @(posedge clock) disable iff (!rst_b)
      act_q && sl_lo |-> pos_q % 3 == 2 && pos_q >= 5 && pos_q <= 47;
  endproperty
  a_slot_pos: assert property (p_slot_pos)
    else $error("slave low outside a request sample clock");
endmodule

// File: test/testbench.sv
// Self-checking bench: slave and host joined over one wire
module testbench;
  import sirq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic               clock;
  logic               rst_b;
  logic [SIRQ_NREQ:1] lv;
  logic               mgmt_n;
  logic               ser_en;
  logic               pin_en;
  logic               go;
  logic               qsel;
  logic [SIRQ_NREQ:1] h_lv;
  logic               h_quiet;
  logic               s_quiet;
  logic               s_act;
  logic               done;
  logic               valid;
  logic               pin_n;
  logic [3:0]         cnt = 4'h0;
  logic [3:0]         run_q = 4'h0;
  int                 err_count;
  int                 checks_done;
  int                 n;
  int                 k;

  sirq_if bus_if ();

  sirq_slave sirq_slave_inst (
    .clock(clock), .rst_b(rst_b), .bus(bus_if), .irq_level(lv),
    .mgmt_interrupt_n(mgmt_n), .mgmt_serial_en(ser_en),
    .mgmt_pin_en(pin_en), .mgmt_interrupt_pin_n(pin_n),
    .quiet_mode(s_quiet), .cycle_active(s_act)
  );

  sirq_host #(.START_CLKS(4'h6)) sirq_host_inst (
    .clock(clock), .rst_b(rst_b), .bus(bus_if), .cycle_go(go),
    .quiet_sel(qsel), .irq_level(h_lv), .quiet_mode(h_quiet),
    .cycle_done(done), .levels_valid(valid)
  );

  sirq_checker sirq_checker_inst (
    .clock(clock), .rst_b(rst_b), .line(bus_if.line),
    .sl_o(bus_if.sl_o), .sl_oe(bus_if.sl_oe),
    .ho_o(bus_if.ho_o), .ho_oe(bus_if.ho_oe)
  );

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // Width of the last low run seen on the wire
  always @(posedge clock) begin
    if (!bus_if.line) begin
      cnt <= cnt + 4'h1;
    end else begin
      if (cnt != 4'h0)
        run_q <= cnt;
      cnt <= 4'h0;
    end
  end

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_vec(input logic [SIRQ_NREQ:1] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_num(input logic [3:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for the host to finish a cycle
  task automatic wait_done();
    n = 0;
    do begin
      tick();
      n++;
    end while (done !== 1'b1 && n < 400);
    if (done !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, done, 1'b1);
      wrap_up();
    end
  endtask

  function automatic logic [SIRQ_NREQ:1] exp_lv();
    logic [SIRQ_NREQ:1] r;
    r = lv;
    if (ser_en && !mgmt_n)
      r[SIRQ_MGMT_SLOT] = 1'b0;
    return r;
  endfunction

  initial begin
    rst_b = 1'b0;
    lv = 15'h2c39;
    mgmt_n = 1'b1;
    ser_en = 1'b0;
    pin_en = 1'b0;
    go = 1'b0;
    qsel = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (20) tick();
    rst_b = 1'b1;
    wait_done();
    chk_vec(h_lv, exp_lv());
    chk_num({3'h0, valid}, 4'h1);
    chk_num(run_q, {2'h0, SIRQ_STOP_CONT});
    chk_num({3'h0, s_quiet}, 4'h0);
    // A level change in continuous mode must wait for the host
    lv[5] = ~lv[5];
    k = 0;
    repeat (150) begin
      tick();
      if (done === 1'b1 || s_act === 1'b1)
        k++;
    end
    chk_num({3'h0, k != 0}, 4'h0);
    qsel = 1'b1;
    go = 1'b1;
    wait_done();
    go = 1'b0;
    chk_vec(h_lv, exp_lv());
    chk_num(run_q, {2'h0, SIRQ_STOP_QUIET});
    chk_num({2'h0, h_quiet, s_quiet}, 4'h3);
    repeat (200) tick();
    // Each slot in turn, next change right at the end of a cycle
    for (int i = 1; i <= SIRQ_NREQ; i++) begin
      lv[i] = ~lv[i];
      wait_done();
      chk_vec(h_lv, exp_lv());
    end
    ser_en = 1'b1;
    pin_en = 1'b1;
    mgmt_n = 1'b0;
    wait_done();
    chk_vec(h_lv, exp_lv());
    chk_num({3'h0, pin_n}, 4'h0);
    ser_en = 1'b0;
    pin_en = 1'b0;
    wait_done();
    chk_vec(h_lv, exp_lv());
    chk_num({3'h0, pin_n}, 4'h1);
    // Back to continuous so the wire is idle before the reset
    qsel = 1'b0;
    go = 1'b1;
    wait_done();
    go = 1'b0;
    chk_num(run_q, {2'h0, SIRQ_STOP_CONT});
    chk_num({2'h0, h_quiet, s_quiet}, 4'h0);
    // Second reset in mid-run
    repeat (30) tick();
    rst_b = 1'b0;
    repeat (3) tick();
    chk_num({2'h0, bus_if.sl_oe, bus_if.ho_oe}, 4'h0);
    rst_b = 1'b1;
    wait_done();
    chk_vec(h_lv, exp_lv());
    wrap_up();
  end
endmodule
